// *** src/pbt_tester.sv ***
// Per-port built-in bit error rate tester
`timescale 1ns/100ps
`include "pbt_regs.svh"
module pbt_tester #(
  parameter int SEC_CYCLES = `PBT_SEC_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [2:0]  pattern_sel,
  input  wire logic        dir_user_sel,
  input  wire logic [1:0]  cts_mode_sel,
  input  wire logic [1:0]  rlsd_mode_sel,
  input  wire logic        set_stb,
  input  wire logic        save_cmd,
  input  wire logic        undo_cmd,
  input  wire logic        refresh_cmd,
  input  wire logic        clear_cmd,
  input  wire logic        single_error_inject,
  input  wire logic        bit_stb,
  input  wire logic        net_rx_bit,
  input  wire logic        user_rx_bit,
  input  wire logic        net_data_in,
  input  wire logic        user_data_in,
  input  wire logic        cts_norm,
  input  wire logic        rlsd_norm,
  input  wire logic        rts_in,
  input  wire logic        subrate_frame_lost,
  output logic             net_tx_bit,
  output logic             user_tx_bit,
  output logic             cts_out,
  output logic             rlsd_out,
  output logic             sync_ok,
  output logic             rts_state,
  output logic [31:0]      bit_error_tally,
  output logic [31:0]      errored_second_tally,
  output logic [31:0]      severe_error_second_tally,
  output logic [31:0]      consecutive_severe_tally,
  output logic [31:0]      unsynced_second_tally,
  output logic [31:0]      subrate_frame_lost_tally,
  output logic [31:0]      test_run_seconds,
  output logic [31:0]      bits_sent_tally,
  output logic [15:0]      ber_ratio
);

  // ----------------------------------------
  // Settings: edit copy and active copy
  // ----------------------------------------
  pbt_pkg::pbt_pat_type   pat_edit_reg, pat_act_reg;
  pbt_pkg::pbt_force_type cts_edit_reg, cts_act_reg, rlsd_edit_reg, rlsd_act_reg;
  logic                   dir_edit_reg, dir_act_reg;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pat_edit_reg  <= pbt_pkg::PAT_OFF;
      dir_edit_reg  <= 1'b0;
      cts_edit_reg  <= pbt_pkg::FRC_NORM;
      rlsd_edit_reg <= pbt_pkg::FRC_NORM;
    end else if (undo_cmd) begin
      pat_edit_reg  <= pat_act_reg;
      dir_edit_reg  <= dir_act_reg;
      cts_edit_reg  <= cts_act_reg;
      rlsd_edit_reg <= rlsd_act_reg;
    end else if (set_stb) begin
      pat_edit_reg  <= pbt_pkg::pbt_pat_type'(pattern_sel);
      dir_edit_reg  <= dir_user_sel;
      cts_edit_reg  <= pbt_pkg::pbt_force_type'(cts_mode_sel);
      rlsd_edit_reg <= pbt_pkg::pbt_force_type'(rlsd_mode_sel);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pat_act_reg  <= pbt_pkg::PAT_OFF;
      dir_act_reg  <= 1'b0;
      cts_act_reg  <= pbt_pkg::FRC_NORM;
      rlsd_act_reg <= pbt_pkg::FRC_NORM;
    end else if (save_cmd && !undo_cmd) begin
      pat_act_reg  <= pat_edit_reg;
      dir_act_reg  <= dir_edit_reg;
      cts_act_reg  <= cts_edit_reg;
      rlsd_act_reg <= rlsd_edit_reg;
    end
  end

  wire running = (pat_act_reg != pbt_pkg::PAT_OFF);
  wire restart = clear_cmd | save_cmd;

  // ----------------------------------------
  // Pattern generator and error insertion
  // ----------------------------------------
  logic [19:0] lfsr_reg;
  logic [2:0]  phase_reg;
  logic        inject_reg;

  wire tx_fb = (pat_act_reg == pbt_pkg::PAT_PRBS511)  ? lfsr_reg[8] ^ lfsr_reg[4] :
               (pat_act_reg == pbt_pkg::PAT_PRBS2047) ? lfsr_reg[10] ^ lfsr_reg[8] :
               lfsr_reg[19] ^ lfsr_reg[16];
  wire tx_pat = (pat_act_reg == pbt_pkg::PAT_MARK)     ? 1'b1 :
                (pat_act_reg == pbt_pkg::PAT_SPACE)    ? 1'b0 :
                (pat_act_reg == pbt_pkg::PAT_ALT)      ? ~phase_reg[0] :
                (pat_act_reg == pbt_pkg::PAT_ONE_IN_8) ? (phase_reg == 3'h0) : tx_fb;
  wire tx_bit = tx_pat ^ inject_reg;
  // Test bits change only on the line strobe, so an inverted bit stands a whole bit time
  wire net_tx_next  = (running && !dir_act_reg) ? (bit_stb ? tx_bit : net_tx_bit) : net_data_in;
  wire user_tx_next = (running && dir_act_reg) ? (bit_stb ? tx_bit : user_tx_bit) : user_data_in;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lfsr_reg  <= `PBT_LFSR_SEED;
      phase_reg <= 3'h0;
    end else if (save_cmd) begin
      lfsr_reg  <= `PBT_LFSR_SEED;
      phase_reg <= 3'h0;
    end else if (bit_stb) begin
      lfsr_reg  <= {lfsr_reg[18:0], tx_fb};
      phase_reg <= phase_reg + 3'h1;
    end
  end

  // A new inject in the consuming cycle stays pending for the next bit
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) inject_reg <= 1'b0;
    else         inject_reg <= single_error_inject | (inject_reg & ~(bit_stb & running));
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      net_tx_bit  <= 1'b0;
      user_tx_bit <= 1'b0;
    end else begin
      net_tx_bit  <= net_tx_next;
      user_tx_bit <= user_tx_next;
    end
  end

  // ----------------------------------------
  // Self-synchronising checker
  // ----------------------------------------
  logic [19:0] rx_hist_reg;
  logic [5:0]  good_run_reg, win_cnt_reg;
  logic [3:0]  win_err_reg;

  wire rx_bit = dir_act_reg ? user_rx_bit : net_rx_bit;
  wire rx_fb  = (pat_act_reg == pbt_pkg::PAT_PRBS511)  ? rx_hist_reg[8] ^ rx_hist_reg[4] :
                (pat_act_reg == pbt_pkg::PAT_PRBS2047) ? rx_hist_reg[10] ^ rx_hist_reg[8] :
                rx_hist_reg[19] ^ rx_hist_reg[16];
  wire rx_exp = (pat_act_reg == pbt_pkg::PAT_MARK)     ? 1'b1 :
                (pat_act_reg == pbt_pkg::PAT_SPACE)    ? 1'b0 :
                (pat_act_reg == pbt_pkg::PAT_ALT)      ? ~rx_hist_reg[0] :
                (pat_act_reg == pbt_pkg::PAT_ONE_IN_8) ? (rx_hist_reg[6:0] == 7'h00) : rx_fb;
  wire bit_err  = bit_stb & running & (rx_bit != rx_exp);
  wire err_cnt  = bit_err & sync_ok;
  wire win_loss = ({1'b0, win_err_reg} + {4'h0, bit_err}) >= {1'b0, `PBT_LOSS_ERRS};

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) rx_hist_reg <= 20'h00000;
    // Once locked the checker free-runs, so one line error counts once
    else if (bit_stb) rx_hist_reg <= {rx_hist_reg[18:0], sync_ok ? rx_exp : rx_bit};
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_ok      <= 1'b0;
      good_run_reg <= 6'h00;
      win_cnt_reg  <= 6'h00;
      win_err_reg  <= 4'h0;
    end else if (!running || save_cmd) begin
      sync_ok      <= 1'b0;
      good_run_reg <= 6'h00;
      win_cnt_reg  <= 6'h00;
      win_err_reg  <= 4'h0;
    end else if (bit_stb && !sync_ok) begin
      good_run_reg <= bit_err ? 6'h00 : good_run_reg + 6'h01;
      sync_ok      <= !bit_err && good_run_reg == `PBT_SYNC_RUN;
      win_cnt_reg  <= 6'h00;
      win_err_reg  <= 4'h0;
    end else if (bit_stb) begin
      win_cnt_reg  <= win_cnt_reg + 6'h01;
      win_err_reg  <= (win_cnt_reg == 6'h3F) ? 4'h0 : win_err_reg + {3'h0, bit_err & ~win_loss};
      if (win_cnt_reg == 6'h3F && win_loss) begin
        sync_ok      <= 1'b0;
        good_run_reg <= 6'h00;
      end
    end
  end

  // ----------------------------------------
  // One-second tick and per-second tallies
  // ----------------------------------------
  logic [24:0] sec_cnt_reg;
  logic [15:0] sec_err_reg, sec_bits_reg;
  logic        sec_unsync_reg, sec_srl_reg, consecutive_severe_tally_on_reg;
  logic [3:0]  ses_run_reg, clean_run_reg;

  wire        sec_tick = (sec_cnt_reg == 25'(SEC_CYCLES - 1));
  wire        sec_es   = (sec_err_reg != 16'h0000);
  wire [25:0] err_k    = {10'h000, sec_err_reg} * `PBT_SES_RATIO;
  wire        sec_ses  = err_k > {10'h000, sec_bits_reg};
  wire        tick_run = sec_tick & running;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sec_cnt_reg    <= 25'h0000000;
      sec_err_reg    <= 16'h0000;
      sec_bits_reg   <= 16'h0000;
      sec_unsync_reg <= 1'b0;
      sec_srl_reg    <= 1'b0;
    end else if (restart || sec_tick) begin
      sec_cnt_reg    <= 25'h0000000;
      sec_err_reg    <= {15'h0000, err_cnt};
      sec_bits_reg   <= {15'h0000, bit_stb & running};
      sec_unsync_reg <= !sync_ok;
      sec_srl_reg    <= subrate_frame_lost;
    end else begin
      sec_cnt_reg    <= sec_cnt_reg + 25'h0000001;
      sec_err_reg    <= sec_err_reg + {15'h0000, err_cnt && sec_err_reg != 16'hFFFF};
      sec_bits_reg   <= sec_bits_reg + {15'h0000, bit_stb && running && sec_bits_reg != 16'hFFFF};
      sec_unsync_reg <= sec_unsync_reg | !sync_ok;
      sec_srl_reg    <= sec_srl_reg | subrate_frame_lost;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ses_run_reg   <= 4'h0;
      clean_run_reg <= 4'h0;
      consecutive_severe_tally_on_reg   <= 1'b0;
    end else if (restart) begin
      ses_run_reg   <= 4'h0;
      clean_run_reg <= 4'h0;
      consecutive_severe_tally_on_reg   <= 1'b0;
    end else if (tick_run && sec_ses) begin
      ses_run_reg   <= (ses_run_reg == `PBT_CONSECUTIVE_SEVERE_TALLY_RUN) ? ses_run_reg : ses_run_reg + 4'h1;
      clean_run_reg <= 4'h0;
      if (ses_run_reg == `PBT_CONSECUTIVE_SEVERE_TALLY_RUN) consecutive_severe_tally_on_reg <= 1'b1;
    end else if (tick_run) begin
      clean_run_reg <= (clean_run_reg == `PBT_CONSECUTIVE_SEVERE_TALLY_RUN) ? clean_run_reg : clean_run_reg + 4'h1;
      ses_run_reg   <= 4'h0;
      if (clean_run_reg == `PBT_CONSECUTIVE_SEVERE_TALLY_RUN) consecutive_severe_tally_on_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Saturating tallies and refresh snapshots
  // ----------------------------------------
  logic [31:0] tally_reg [`PBT_NUM_TALLY];
  logic [31:0] snap_reg  [`PBT_NUM_TALLY];
  wire  [`PBT_NUM_TALLY-1:0] tally_inc = {bit_stb & running,
                                          tick_run,
                                          tick_run & sec_srl_reg,
                                          tick_run & sec_unsync_reg,
                                          tick_run & consecutive_severe_tally_on_reg,
                                          tick_run & sec_ses,
                                          tick_run & sec_es,
                                          err_cnt};

  for (genvar i = 0; i < `PBT_NUM_TALLY; i++) begin : g_tally
    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) tally_reg[i] <= 32'h00000000;
      else if (restart) tally_reg[i] <= 32'h00000000;
      else if (tally_inc[i] && tally_reg[i] != 32'hFFFFFFFF) tally_reg[i] <= tally_reg[i] + 32'h00000001;
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) snap_reg[i] <= 32'h00000000;
      else if (clear_cmd) snap_reg[i] <= 32'h00000000;
      else if (refresh_cmd) snap_reg[i] <= tally_reg[i];
    end
  end

  assign bit_error_tally           = snap_reg[`PBT_T_BE];
  assign errored_second_tally      = snap_reg[`PBT_T_ES];
  assign severe_error_second_tally = snap_reg[`PBT_T_SES];
  assign consecutive_severe_tally  = snap_reg[`PBT_T_CONSECUTIVE_SEVERE_TALLY];
  assign unsynced_second_tally     = snap_reg[`PBT_T_OSS];
  assign subrate_frame_lost_tally  = snap_reg[`PBT_T_SRL];
  assign test_run_seconds          = snap_reg[`PBT_T_RUN];
  assign bits_sent_tally           = snap_reg[`PBT_T_BITS];

  // ----------------------------------------
  // Error ratio: 16-bit binary fraction
  // ----------------------------------------
  logic        div_go_reg;
  logic [4:0]  div_cnt_reg;
  logic [32:0] div_rem_reg;
  logic [15:0] div_q_reg;
  wire  [31:0] div_num = snap_reg[`PBT_T_BE];
  wire  [31:0] div_den = snap_reg[`PBT_T_BITS];
  wire  [32:0] rem_sh  = {div_rem_reg[31:0], 1'b0};
  wire         rem_ge  = rem_sh >= {1'b0, div_den};

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_go_reg  <= 1'b0;
      div_cnt_reg <= 5'h00;
      div_rem_reg <= 33'h000000000;
      div_q_reg   <= 16'h0000;
      ber_ratio   <= 16'h0000;
    end else begin
      div_go_reg <= refresh_cmd & ~clear_cmd;
      if (clear_cmd) begin
        div_cnt_reg <= 5'h00;
        ber_ratio   <= 16'h0000;
      end else if (div_go_reg) begin
        div_rem_reg <= {1'b0, div_num};
        div_q_reg   <= 16'h0000;
        div_cnt_reg <= (div_den != 32'h0 && div_num < div_den) ? `PBT_DIV_STEPS : 5'h00;
        if (div_den == 32'h0) ber_ratio <= 16'h0000;
        else if (div_num >= div_den) ber_ratio <= 16'hFFFF;
      end else if (div_cnt_reg != 5'h00) begin
        div_rem_reg <= rem_ge ? rem_sh - {1'b0, div_den} : rem_sh;
        div_q_reg   <= {div_q_reg[14:0], rem_ge};
        div_cnt_reg <= div_cnt_reg - 5'h01;
        if (div_cnt_reg == 5'h01) ber_ratio <= {div_q_reg[14:0], rem_ge};
      end
    end
  end

  // ----------------------------------------
  // Modem control leads
  // ----------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cts_out   <= 1'b0;
      rlsd_out  <= 1'b0;
      rts_state <= 1'b0;
    end else begin
      cts_out   <= (cts_act_reg == pbt_pkg::FRC_ON) | (cts_act_reg != pbt_pkg::FRC_OFF & cts_norm);
      rlsd_out  <= (rlsd_act_reg == pbt_pkg::FRC_ON) | (rlsd_act_reg != pbt_pkg::FRC_OFF & rlsd_norm);
      rts_state <= rts_in;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_inject_one_bit: assert property (@(posedge mclk) disable iff (sys_rst)
    inject_reg && bit_stb && running && !dir_act_reg && !save_cmd |=> net_tx_bit == ~$past(tx_pat))
    else $error("inject did not invert the bit");
  a_cts_forced: assert property (@(posedge mclk) disable iff (sys_rst)
    cts_act_reg == pbt_pkg::FRC_OFF |=> !cts_out)
    else $error("cts not held off");
  a_rlsd_normal: assert property (@(posedge mclk) disable iff (sys_rst)
    rlsd_act_reg == pbt_pkg::FRC_NORM |=> rlsd_out == $past(rlsd_norm))
    else $error("rlsd does not follow normal lead");
  a_clear_zeroes: assert property (@(posedge mclk) disable iff (sys_rst)
    clear_cmd |=> tally_reg[`PBT_T_BE] == 32'h0 && bit_error_tally == 32'h0 && test_run_seconds == 32'h0)
    else $error("clear left a counter");
  a_run_seconds: assert property (@(posedge mclk) disable iff (sys_rst)
    tick_run && !restart && tally_reg[`PBT_T_RUN] != 32'hFFFFFFFF
    |=> tally_reg[`PBT_T_RUN] == $past(tally_reg[`PBT_T_RUN]) + 32'h1)
    else $error("elapsed seconds missed a tick");
  a_sync_off: assert property (@(posedge mclk) disable iff (sys_rst)
    !running |=> !sync_ok)
    else $error("sync reported with pattern off");
  a_errored_sec: assert property (@(posedge mclk) disable iff (sys_rst)
    tick_run && sec_es && !restart && tally_reg[`PBT_T_ES] != 32'hFFFFFFFF
    |=> tally_reg[`PBT_T_ES] != $past(tally_reg[`PBT_T_ES]))
    else $error("errored second not counted");
  a_undo_restore: assert property (@(posedge mclk) disable iff (sys_rst)
    undo_cmd |=> pat_edit_reg == pat_act_reg && dir_edit_reg == dir_act_reg)
    else $error("undo did not restore settings");
  a_refresh_snap: assert property (@(posedge mclk) disable iff (sys_rst)
    refresh_cmd && !clear_cmd |=> test_run_seconds == $past(tally_reg[`PBT_T_RUN]))
    else $error("refresh snapshot wrong");
  a_rts_report: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 rts_state == $past(rts_in))
    else $error("rts state stale");

endmodule // pbt_tester

// *** src/pbt_regs.svh ***
// Constants for the port bit error tester
// Behaviour
// - Selected pattern goes out the chosen port; errors measured on the return.
// - Quasi-random option exists; pattern defaults to off after reset.
// - Direction selects network side (default) or terminal side.
// - Clear-to-send forced on, off, or left normal (default).
// - Line signal detect forced on, off, or left normal (default).
// - Report receiver lock to expected pattern, local or remote source.
// - Count received bit errors while synchronized, since last clear.
// - Count seconds with at least one bit error.
// - Count seconds whose error ratio exceeds one per thousand bits.
// - After ten severe seconds count every second until ten clean ones.
// - Count seconds during which the receiver is not synchronized.
// - Bit error ratio is error count over bits sent.
// - Count seconds elapsed since the test began.
// - Report request-to-send input as on or off.
// - Count seconds with subrate framing lost.
// - Each inject command inverts one outgoing bit; injects before that bit goes out merge into one.
// - Clear zeroes every counter at once.
// - Settings act only when saved; undo restores saved values.
// - Refresh delivers new snapshots of time-related values.
`ifndef PBT_REGS_SVH
`define PBT_REGS_SVH
`define PBT_CLK_NS      40
`define PBT_SECOND_NS   1000000000
`define PBT_SEC_CYCLES  (`PBT_SECOND_NS / `PBT_CLK_NS)
`define PBT_SYNC_RUN    6'h1F
`define PBT_LOSS_ERRS   4'h8
`define PBT_LFSR_SEED   20'hFFFFF
`define PBT_SES_RATIO   26'h00003E8
`define PBT_CONSECUTIVE_SEVERE_TALLY_RUN    4'h9
`define PBT_DIV_STEPS   5'h10
`define PBT_NUM_TALLY   8
`define PBT_T_BE        0
`define PBT_T_ES        1
`define PBT_T_SES       2
`define PBT_T_CONSECUTIVE_SEVERE_TALLY      3
`define PBT_T_OSS       4
`define PBT_T_SRL       5
`define PBT_T_RUN       6
`define PBT_T_BITS      7
`endif

// *** src/pbt_pkg.sv ***
// Types for the port bit error tester
package pbt_pkg;
  typedef enum logic [2:0] {PAT_OFF, PAT_MARK, PAT_SPACE, PAT_ALT, PAT_ONE_IN_8,
                            PAT_PRBS511, PAT_QRSS, PAT_PRBS2047} pbt_pat_type;
  typedef enum logic [1:0] {FRC_NORM, FRC_OFF, FRC_ON} pbt_force_type;
endpackage

// *** sim/pbt_far_end.sv ***
// Far-end model: remote loopback with single-bit corruption, inverted line when unlooped
`timescale 1ns/100ps
module pbt_far_end (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic loop_en,
  input  wire logic flip_req,
  input  wire logic tx_bit,
  output logic      bit_stb,
  output logic      rx_bit
);
  logic flip_pend;
  // --------------------------------------------------------
  // Line timing: one bit strobe every second cycle
  // --------------------------------------------------------
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_stb   <= #1 1'b0;
      flip_pend <= #1 1'b0;
    end else begin
      bit_stb <= #1 ~bit_stb;
      if (flip_req) begin
        flip_pend <= #1 1'b1;
      end else if (bit_stb) begin
        flip_pend <= #1 1'b0;
      end
    end
  end
  // Looped return, one corrupted bit on request; unlooped line returns the inverse
  assign rx_bit = loop_en ? (tx_bit ^ flip_pend) : ~tx_bit;
endmodule // pbt_far_end

// *** sim/tb_port_bit_error_tester.sv ***
// Self-checking testbench for the port bit error tester
`timescale 1ns/100ps
module tb_port_bit_error_tester;
  localparam int SEC = 50;
  logic        mclk, sys_rst, dir_user_sel, set_stb, save_cmd, undo_cmd, refresh_cmd, clear_cmd;
  logic        single_error_inject, bit_stb, net_rx_bit, user_rx_bit, net_data_in, user_data_in;
  logic        cts_norm, rlsd_norm, rts_in, subrate_frame_lost, loop_en, flip_req;
  logic        net_tx_bit, user_tx_bit, cts_out, rlsd_out, sync_ok, rts_state;
  logic [2:0]  pattern_sel;
  logic [1:0]  cts_mode_sel, rlsd_mode_sel;
  logic [31:0] bet, est, sest, cst, ust, srt, run_s, bst;
  logic [15:0] ber_ratio;
  logic [39:0] bits;
  int          errors, comparisons, nbits, bad, ber_exp;

  pbt_tester #(.SEC_CYCLES(SEC)) dut (.mclk(mclk), .sys_rst(sys_rst), .pattern_sel(pattern_sel),
    .dir_user_sel(dir_user_sel), .cts_mode_sel(cts_mode_sel), .rlsd_mode_sel(rlsd_mode_sel),
    .set_stb(set_stb), .save_cmd(save_cmd), .undo_cmd(undo_cmd), .refresh_cmd(refresh_cmd),
    .clear_cmd(clear_cmd), .single_error_inject(single_error_inject), .bit_stb(bit_stb),
    .net_rx_bit(net_rx_bit), .user_rx_bit(user_rx_bit), .net_data_in(net_data_in),
    .user_data_in(user_data_in), .cts_norm(cts_norm), .rlsd_norm(rlsd_norm), .rts_in(rts_in),
    .subrate_frame_lost(subrate_frame_lost), .net_tx_bit(net_tx_bit), .user_tx_bit(user_tx_bit),
    .cts_out(cts_out), .rlsd_out(rlsd_out), .sync_ok(sync_ok), .rts_state(rts_state),
    .bit_error_tally(bet), .errored_second_tally(est), .severe_error_second_tally(sest),
    .consecutive_severe_tally(cst), .unsynced_second_tally(ust), .subrate_frame_lost_tally(srt),
    .test_run_seconds(run_s), .bits_sent_tally(bst), .ber_ratio(ber_ratio));

  pbt_far_end far (.mclk(mclk), .sys_rst(sys_rst), .loop_en(loop_en), .flip_req(flip_req),
    .tx_bit(net_tx_bit), .bit_stb(bit_stb), .rx_bit(net_rx_bit));

  // --------------------------------------------------------
  // Clock, bit count and watchdog
  // --------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) if (bit_stb === 1'b1) nbits++;
  initial begin
    #400000;
    errors++;
    $display("watchdog expired");
    finish_test();
  end

  // --------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Pulses {set, save, undo, refresh, clear} for one cycle
  task automatic cmd(input logic [4:0] m);
    {set_stb, save_cmd, undo_cmd, refresh_cmd, clear_cmd} = m;
    cyc(1);
    {set_stb, save_cmd, undo_cmd, refresh_cmd, clear_cmd} = 5'h00;
  endtask
  task automatic cfg(input logic [2:0] p, input logic d, input logic [1:0] c, input logic sv);
    pattern_sel = p;
    dir_user_sel = d;
    cts_mode_sel = c;
    rlsd_mode_sel = c;
    cmd(5'h10);
    if (sv) begin
      cyc(1);
      cmd(5'h08);
    end
    cyc(3);
  endtask
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // --------------------------------------------------------
  // Tests
  // --------------------------------------------------------
  initial begin
    {set_stb, save_cmd, undo_cmd, refresh_cmd, clear_cmd} = 5'h00;
    {single_error_inject, user_rx_bit, net_data_in, user_data_in, rts_in} = 5'h06;
    {cts_norm, rlsd_norm, subrate_frame_lost, loop_en, flip_req} = 5'h10;
    {pattern_sel, dir_user_sel, cts_mode_sel, rlsd_mode_sel} = 8'h00;
    errors = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    cyc(4);
    sys_rst = 1'b0;
    cyc(3);
    chk("tallies", 32'h0, bet | est | sest | cst | ust | srt | run_s | bst | ber_ratio);
    chk("sync", 32'h0, sync_ok);
    chk("off net", {31'h0, net_data_in}, net_tx_bit);
    chk("off user", {31'h0, user_data_in}, user_tx_bit);
    $display("test defaults done");
    for (int m = 0; m < 3; m++) begin
      cfg(3'h0, 1'b0, m[1:0], 1'b1);
      for (int v = 0; v < 2; v++) begin
        cts_norm = v[0];
        rlsd_norm = ~v[0];
        cyc(2);
        chk("cts", (m == 0) ? v : (m == 2), cts_out);
        chk("rlsd", (m == 0) ? !v : (m == 2), rlsd_out);
      end
    end
    cfg(3'h0, 1'b0, 2'h1, 1'b0);
    chk("cts unsaved", 32'h1, cts_out);
    cmd(5'h08);
    cyc(2);
    chk("cts saved", 32'h0, cts_out);
    cfg(3'h0, 1'b0, 2'h2, 1'b0);
    cmd(5'h04);
    cyc(1);
    cmd(5'h08);
    cyc(2);
    chk("cts undo", 32'h0, cts_out);
    cfg(3'h0, 1'b0, 2'h0, 1'b1);
    rts_in = 1'b1;
    cyc(2);
    chk("rts on", 32'h1, rts_state);
    rts_in = 1'b0;
    cyc(2);
    chk("rts off", 32'h0, rts_state);
    $display("test leads done");
    for (int p = 1; p < 8; p++) begin
      cfg(p[2:0], p == 3, 2'h0, 1'b1);
      cyc(10);
      for (int i = 0; i < 40; i++) begin
        @(negedge mclk);
        while (bit_stb !== 1'b1) @(negedge mclk);
        bits[i] = (p == 3) ? user_tx_bit : net_tx_bit;
      end
      cyc(1);
      bad = 0;
      for (int n = 20; n < 40; n++) begin
        case (p)
          1: bad += (bits[n] !== 1'b1);
          2: bad += (bits[n] !== 1'b0);
          3: bad += (bits[n] === bits[n-1]);
          4: bad += (bits[n] !== bits[n-8]) || ($countones(bits[n-7 +: 8]) != 1);
          5: bad += (bits[n] !== (bits[n-9] ^ bits[n-5]));
          6: bad += (bits[n] !== (bits[n-20] ^ bits[n-17]));
          default: bad += (bits[n] !== (bits[n-11] ^ bits[n-9]));
        endcase
      end
      chk("pattern stream", 32'h0, bad);
      if (p == 3) chk("net pass", {31'h0, net_data_in}, net_tx_bit);
    end
    $display("test patterns done");
    loop_en = 1'b1;
    cfg(3'h5, 1'b0, 2'h0, 1'b0);
    cmd(5'h08);
    nbits = 0;
    for (int s = 1; s <= 27; s++) begin
      cyc(25);
      if (s == 3) chk("sync lock", 32'h1, sync_ok);
      single_error_inject = (s >= 4 && s <= 9);
      flip_req = (s >= 10 && s <= 15);
      subrate_frame_lost = (s == 5 || s == 6);
      cyc(1);
      {single_error_inject, flip_req} = 2'h0;
      cyc(23);
      subrate_frame_lost = 1'b0;
      cyc(1);
    end
    cyc(10);
    cmd(5'h02);
    ber_exp = (12 * 65536) / nbits;
    chk("bits sent", 32'h1, (bst + 1 >= nbits) && (bst <= nbits));
    cyc(1);
    chk("bit errors", 32'd12, bet);
    chk("errored s", 32'd12, est);
    chk("severe s", 32'd12, sest);
    chk("consec severe", 32'd12, cst);
    chk("unsynced s", 32'd2, ust);
    chk("subrate s", 32'd2, srt);
    chk("elapsed", 32'd27, run_s);
    cyc(20);
    chk("ber near", 32'h1, (ber_ratio + 3 > ber_exp) && (ber_ratio < ber_exp + 3));
    cyc(60);
    chk("snapshot held", 32'd27, run_s);
    $display("test seconds done");
    cmd(5'h03);
    cyc(2);
    chk("cleared", 32'h0, bet | est | sest | cst | ust | srt | run_s | bst | ber_ratio);
    loop_en = 1'b0;
    cyc(300);
    chk("sync lost", 32'h0, sync_ok);
    $display("test clear and loss done");
    finish_test();
  end
endmodule // tb_port_bit_error_tester
